// [include/lcgis_pkg.sv]
// Constants for the logic cell gate input select stage.
// Function
// - Low bit 3 set passes source two true into gate one; clear blocks it.
// - Low bit 2 set passes inverted source two into gate one.
// - Low bit 1 set passes source one true into gate one.
// - Low bit 0 set passes inverted source one into gate one.
// - High bits 15..8 are gate four enables, source four down to one.
// - A gate four negated enable routes the inverted source, e.g. bit 12.
// - A clear gate four true enable blocks that source, e.g. bit 9.
// - True and negated enables of one source are independent bits.
// - High bits 7..0 are gate three enables in the same order.
// - High bit 3 set passes source two true into gate three.
// - High bit 2 set passes inverted source two into gate three.
// - High bit 1 set passes source one true into gate three.
// - High bit 0 set passes inverted source one into gate three.
// - Source n is input mux n, chosen by a three-bit select field.
package lcgis_pkg;
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEL_W  = 3;
  localparam int unsigned N_SRC  = 4;
  localparam int unsigned N_MUX_IN = 8;
  localparam logic [1:0] GLS_LOW_ADDR  = 2'h0;
  localparam logic [1:0] GLS_HIGH_ADDR = 2'h1;
  localparam logic [1:0] MUX_SEL_ADDR  = 2'h2;
  localparam logic [1:0] GATE_OUT_ADDR = 2'h3;
  localparam logic [15:0] GLS_LOW_RST  = 16'h0000;
  localparam logic [15:0] GLS_HIGH_RST = 16'h0000;
  localparam logic [15:0] MUX_SEL_RST  = 16'h0000;
  localparam logic [15:0] MUX_SEL_MASK = 16'h7777;
  localparam int unsigned GATE1_LSB = 0;
  localparam int unsigned GATE2_LSB = 8;
  localparam int unsigned GATE3_LSB = 0;
  localparam int unsigned GATE4_LSB = 8;
  localparam int unsigned GATE1_LOW_W = 4;
endpackage

// [design/lcgis_gate.sv]
// One gate: OR of enabled true and inverted source paths.
`timescale 1ns/1ps
module lcgis_gate
  import lcgis_pkg::*;
#(
  parameter int unsigned NSRC = 4
)
(
  // Enables, per source a true bit above an inverted bit
  input  wire logic [2*NSRC-1:0] en,
  // Data sources
  input  wire logic [NSRC-1:0]   src,
  // Gate result
  output logic                   gate
);
  always_comb
  begin
    gate = 1'b0;
    for (int i = 0; i < NSRC; i++)
    begin
      gate = gate | (en[2*i+1] & src[i]);
      gate = gate | (en[2*i] & ~src[i]);
    end
  end
endmodule

// [design/lcgis_top.sv]
// Gate input select stage with register port and input multiplexers.
`timescale 1ns/1ps
module lcgis_top
  import lcgis_pkg::*;
#(
  parameter int unsigned NIN = N_MUX_IN
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Mux candidate signals, one vector per data source
  input  wire logic [NIN-1:0]    mux1_in,
  input  wire logic [NIN-1:0]    mux2_in,
  input  wire logic [NIN-1:0]    mux3_in,
  input  wire logic [NIN-1:0]    mux4_in,
  // Gate outputs
  output logic [3:0]             gate_out
);
  logic              rst_meta;
  logic              rst_n;
  logic [DATA_W-1:0] gate_input_select_low;
  logic [DATA_W-1:0] gate_input_select_high;
  logic [DATA_W-1:0] input_mux_select_reg;
  logic [N_SRC-1:0]  src;
  logic [3:0]        next_gate;
  logic [7:0]        gate1_en;

  function automatic logic pick(input logic [NIN-1:0] v,
                                input logic [SEL_W-1:0] s);
    pick = v[s];
  endfunction

  // Reset release through two flops.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Register writes.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_input_select_low  <= GLS_LOW_RST;
      gate_input_select_high <= GLS_HIGH_RST;
      input_mux_select_reg   <= MUX_SEL_RST;
    end
    else if (wr)
    begin
      unique case (addr)
        GLS_LOW_ADDR:  gate_input_select_low  <= wdata;
        GLS_HIGH_ADDR: gate_input_select_high <= wdata;
        MUX_SEL_ADDR:  input_mux_select_reg   <= wdata & MUX_SEL_MASK;
        GATE_OUT_ADDR: ;
      endcase
    end
  end

  // Register reads, data valid the cycle after the strobe.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (rd)
    begin
      unique case (addr)
        GLS_LOW_ADDR:  rdata <= gate_input_select_low;
        GLS_HIGH_ADDR: rdata <= gate_input_select_high;
        MUX_SEL_ADDR:  rdata <= input_mux_select_reg;
        GATE_OUT_ADDR: rdata <= {12'h000, gate_out};
      endcase
    end
    else
      rdata <= '0;
  end

  // Source n comes from input mux n.
  always_comb
  begin
    src[0] = pick(mux1_in, input_mux_select_reg[2:0]);
    src[1] = pick(mux2_in, input_mux_select_reg[6:4]);
    src[2] = pick(mux3_in, input_mux_select_reg[10:8]);
    src[3] = pick(mux4_in, input_mux_select_reg[14:12]);
  end

  // Gate one uses only sources one and two.
  assign gate1_en = {4'h0,
                     gate_input_select_low[GATE1_LSB +: GATE1_LOW_W]};

  lcgis_gate #(.NSRC(N_SRC)) u_gate1
  (
    .en   (gate1_en),
    .src  (src),
    .gate (next_gate[0])
  );

  lcgis_gate #(.NSRC(N_SRC)) u_gate2
  (
    .en   (gate_input_select_low[GATE2_LSB +: 8]),
    .src  (src),
    .gate (next_gate[1])
  );

  lcgis_gate #(.NSRC(N_SRC)) u_gate3
  (
    .en   (gate_input_select_high[GATE3_LSB +: 8]),
    .src  (src),
    .gate (next_gate[2])
  );

  lcgis_gate #(.NSRC(N_SRC)) u_gate4
  (
    .en   (gate_input_select_high[GATE4_LSB +: 8]),
    .src  (src),
    .gate (next_gate[3])
  );

  // Registered gate outputs.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      gate_out <= 4'h0;
    else
      gate_out <= next_gate;
  end
endmodule

// [testbench/lcgis_props.sv]
// Assertion checker for the gate input select stage.
`timescale 1ns/1ps
module lcgis_props
  import lcgis_pkg::*;
#(
  parameter int unsigned NIN = N_MUX_IN
)
(
  input wire logic sys_clk, nrst, wr, rd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata, rdata,
  input wire logic [NIN-1:0] mux1_in, mux2_in, mux3_in, mux4_in,
  input wire logic [3:0] gate_out
);
  logic [15:0] lo, hi, ms;
  logic        s1, s2, s3, s4, e1, e3, e4;
  logic [7:0]  v;
  // Shadow copies of the select registers.
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      lo <= 16'h0000;
      hi <= 16'h0000;
      ms <= 16'h0000;
    end
    else if (wr)
    begin
      if (addr == GLS_LOW_ADDR) lo <= wdata;
      if (addr == GLS_HIGH_ADDR) hi <= wdata;
      if (addr == MUX_SEL_ADDR) ms <= wdata;
    end
  assign s1 = mux1_in[ms[2:0]];
  assign s2 = mux2_in[ms[6:4]];
  assign s3 = mux3_in[ms[10:8]];
  assign s4 = mux4_in[ms[14:12]];
  assign v  = {s4, ~s4, s3, ~s3, s2, ~s2, s1, ~s1};
  assign e1 = |(lo[3:0] & v[3:0]);
  assign e3 = |(hi[7:0] & v);
  assign e4 = |(hi[15:8] & v);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_G1_T2: assert property (lo[3] && s2 |=> gate_out[0])
    else $error("gate one lost true source two");
  AST_G1_N2: assert property (lo[2] && !s2 |=> gate_out[0])
    else $error("gate one lost inverted source two");
  AST_G1_T1: assert property (lo[1] && s1 |=> gate_out[0])
    else $error("gate one lost true source one");
  AST_G1_N1: assert property (lo[0] && !s1 |=> gate_out[0])
    else $error("gate one lost inverted source one");
  AST_G1: assert property (gate_out[0] == $past(e1))
    else $error("gate one value wrong");
  AST_G3: assert property (gate_out[2] == $past(e3))
    else $error("gate three value wrong");
  AST_G4: assert property (gate_out[3] == $past(e4))
    else $error("gate four value wrong");
  AST_RD_HI: assert property (rd && addr == GLS_HIGH_ADDR
    |=> rdata == $past(hi)) else $error("high readback wrong");
  AST_RD_IDLE: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data not idle");
endmodule
bind lcgis_top lcgis_props #(.NIN(NIN)) u_props (.sys_clk(sys_clk),
  .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .mux1_in(mux1_in), .mux2_in(mux2_in),
  .mux3_in(mux3_in), .mux4_in(mux4_in), .gate_out(gate_out));

// [testbench/lcgis_tb.sv]
// Self-checking bench for the gate input select stage.
`timescale 1ns/1ps
module lcgis_tb;
  import lcgis_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000, rdata, d;
  logic [7:0] m = 8'h00;
  logic [3:0] gate_out;
  int fail_count = 0, total_checks = 0;
  lcgis_top uut (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mux1_in(m),
    .mux2_in(m), .mux3_in(m), .mux4_in(m), .gate_out(gate_out));
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (e !== g)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(logic [1:0] a, logic [15:0] x);
    @(posedge sys_clk);
    {addr, wdata, wr} <= {a, x, 1'b1};
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [1:0] a);
    @(posedge sys_clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask
  task automatic gchk(logic [7:0] s, logic [3:0] e);
    @(posedge sys_clk);
    m <= s;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("gate_out", {12'h000, e}, {12'h000, gate_out});
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rreg(GLS_LOW_ADDR);
    chk("low", 16'h0000, d);
    rreg(GLS_HIGH_ADDR);
    chk("high", GLS_HIGH_RST, d);
    gchk(8'hff, 4'h0);
    $display("test reset done");
    for (int b = 0; b < 4; b++)
      for (int v = 0; v < 2; v++)
      begin
        wreg(GLS_LOW_ADDR, 16'h0001 << b);
        gchk({8{v[0]}}, {3'h0, v[0] == b[0]});
      end
    $display("test gate one done");
    wreg(GLS_LOW_ADDR, 16'h0000);
    for (int b = 0; b < 16; b++)
      for (int v = 0; v < 2; v++)
      begin
        wreg(GLS_HIGH_ADDR, 16'h0001 << b);
        rreg(GLS_HIGH_ADDR);
        chk("high", 16'h0001 << b, d);
        gchk({8{v[0]}}, {3'h0, v[0] == b[0]} << (b / 8 + 2));
      end
    wreg(GLS_HIGH_ADDR, 16'h0c00);
    gchk(8'h00, 4'h8);
    gchk(8'hff, 4'h8);
    $display("test gates three four done");
    wreg(GLS_HIGH_ADDR, 16'h0000);
    wreg(GLS_LOW_ADDR, 16'h0002);
    wreg(MUX_SEL_ADDR, 16'h0005);
    rreg(GLS_LOW_ADDR);
    chk("low", 16'h0002, d);
    rreg(MUX_SEL_ADDR);
    chk("mux select", 16'h0005, d);
    for (int i = 0; i < 8; i++)
      gchk(8'h01 << i, {3'h0, i == 5});
    $display("test mux select done");
    stop_test;
  end
  initial
  begin
    #20000;
    fail_count++;
    stop_test;
  end
endmodule
